// >>> tap_changer_voltage_regulator.sv
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tap_changer_voltage_regulator (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // measurements, one set per time-base tick
  input wire logic sample_valid,
  input wire logic [15:0] voltage_pct,
  input wire logic [15:0] current_l1,
  input wire logic [15:0] current_l2,
  input wire logic [15:0] current_l3,
  input wire logic [15:0] pos_resistance,
  input wire logic [15:0] pos_di_voltage,
  input wire logic ext_block,
  // tap changer commands and status
  output logic raise_cmd_q,
  output logic lower_cmd_q,
  output logic [7:0] tap_position_q,
  output logic irq_q
);

  logic [avr_pkg::CTRL_W-1:0] ctrl_q;
  logic [avr_pkg::EV_W-1:0] status_q;
  logic [avr_pkg::EV_W-1:0] mask_q;
  logic [31:0] gain_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] araddr_q;
  avr_pkg::rd_state_t rd_q;
  logic up_q;
  logic dn_q;
  logic lv_q;
  logic oc_q;
  logic ext_q;
  avr_pkg::region_t region_q;
  avr_pkg::region_t region_d;
  logic [31:0] acc_q;
  logic [31:0] acc_d;
  logic [15:0] gap_q;
  logic [avr_pkg::PW-1:0] bank_rdata;
  logic [avr_pkg::NPAR*avr_pkg::PW-1:0] act;

  // write path decode
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  wire aw_hi_zero = awaddr_q[31:8] == 24'h000000;
  wire wr_bank = aw_hi_zero && awaddr_q[avr_pkg::BANK_SEL_BIT];
  wire wr_ctrl = aw_hi_zero && awaddr_q[7:0] == avr_pkg::OFS_CTRL;
  wire wr_status = aw_hi_zero && awaddr_q[7:0] == avr_pkg::OFS_STATUS;
  wire wr_mask = aw_hi_zero && awaddr_q[7:0] == avr_pkg::OFS_MASK;
  wire wr_gain = aw_hi_zero && awaddr_q[7:0] == avr_pkg::OFS_POS_GAIN;
  wire wr_ok = wr_bank || wr_ctrl || wr_status || wr_mask || wr_gain ||
               (aw_hi_zero && awaddr_q[7:0] == avr_pkg::OFS_STATE);
  wire [31:0] wr_merge_ctrl = ({28'h0, ctrl_q} & ~wmask) | (wdata_q & wmask);
  wire [31:0] wr_merge_mask = ({28'h0, mask_q} & ~wmask) | (wdata_q & wmask);
  wire [31:0] wr_merge_gain = (gain_q & ~wmask) | (wdata_q & wmask);
  wire [avr_pkg::EV_W-1:0] clr_bits = wr_fire && wr_status ?
                                      wdata_q[avr_pkg::EV_W-1:0] & wmask[avr_pkg::EV_W-1:0] :
                                      '0;
  wire bank_we = wr_fire && wr_bank && wstrb_q[1:0] == 2'b11;

  // read path decode
  wire ar_hi_zero = araddr_q[31:8] == 24'h000000;
  wire rd_bank = ar_hi_zero && araddr_q[avr_pkg::BANK_SEL_BIT];
  wire rd_ctrl = ar_hi_zero && araddr_q[7:0] == avr_pkg::OFS_CTRL;
  wire rd_status = ar_hi_zero && araddr_q[7:0] == avr_pkg::OFS_STATUS;
  wire rd_mask = ar_hi_zero && araddr_q[7:0] == avr_pkg::OFS_MASK;
  wire rd_state = ar_hi_zero && araddr_q[7:0] == avr_pkg::OFS_STATE;
  wire rd_gain = ar_hi_zero && araddr_q[7:0] == avr_pkg::OFS_POS_GAIN;
  wire rd_ok = rd_bank || rd_ctrl || rd_status || rd_mask || rd_state || rd_gain;
  wire [31:0] state_word = ({30'h0, dn_q, up_q} << avr_pkg::ST_PICK_LSB) |
                           ({29'h0, ext_q, oc_q, lv_q} << avr_pkg::ST_BLK_LSB) |
                           ({28'h0, region_q} << avr_pkg::ST_REG_LSB) |
                           ({24'h0, tap_position_q} << avr_pkg::ST_POS_LSB);
  wire [31:0] rd_word = rd_bank ? {16'h0, bank_rdata} :
                        rd_ctrl ? {28'h0, ctrl_q} :
                        rd_status ? {28'h0, status_q} :
                        rd_mask ? {28'h0, mask_q} :
                        rd_state ? state_word :
                        rd_gain ? gain_q : 32'h0;

  // active group settings
  wire [15:0] target_voltage = act[avr_pkg::P_TARGET*avr_pkg::PW +: avr_pkg::PW];
  wire [15:0] w1_hi = act[avr_pkg::P_W1_HI*avr_pkg::PW +: avr_pkg::PW];
  wire [15:0] w1_lo = act[avr_pkg::P_W1_LO*avr_pkg::PW +: avr_pkg::PW];
  wire [15:0] w2_band = act[avr_pkg::P_W2*avr_pkg::PW +: avr_pkg::PW];
  wire [15:0] instant = act[avr_pkg::P_INSTANT*avr_pkg::PW +: avr_pkg::PW];
  wire [15:0] lv_level = act[avr_pkg::P_LV_BLOCK*avr_pkg::PW +: avr_pkg::PW];
  wire [15:0] t1_ticks = act[avr_pkg::P_T1*avr_pkg::PW +: avr_pkg::PW];
  wire [15:0] t2_ticks = act[avr_pkg::P_T2*avr_pkg::PW +: avr_pkg::PW];
  wire [15:0] min_gap = act[avr_pkg::P_MIN_GAP*avr_pkg::PW +: avr_pkg::PW];
  wire [15:0] oc_level = act[avr_pkg::P_OC_LEVEL*avr_pkg::PW +: avr_pkg::PW];

  // deviation from target, window limits relative to it; low-voltage and overcurrent levels are absolute
  wire [17:0] dev = {2'b00, voltage_pct} - {2'b00, target_voltage};
  wire dev_pos = !dev[17];
  wire [17:0] dev_neg = 18'h00000 - dev;
  wire [16:0] absdev = dev_pos ? dev[16:0] : dev_neg[16:0];

  // release levels keep 97 percent of the pick-up band
  wire [31:0] hi_keep = 32'(({16'h0, w1_hi} * 32'(avr_pkg::PCT_DIV - avr_pkg::HYST_PCT)) /
                            32'(avr_pkg::PCT_DIV));
  wire [31:0] lo_keep = 32'(({16'h0, w1_lo} * 32'(avr_pkg::PCT_DIV - avr_pkg::HYST_PCT)) /
                            32'(avr_pkg::PCT_DIV));
  wire up_set = dev_pos && {15'h0, absdev} > {16'h0, w1_hi};
  wire dn_set = !dev_pos && {15'h0, absdev} > {16'h0, w1_lo};
  wire up_keep = dev_pos && {15'h0, absdev} > hi_keep;
  wire dn_keep = !dev_pos && {15'h0, absdev} > lo_keep;
  wire up_d = up_set || (up_q && up_keep);
  wire dn_d = dn_set || (dn_q && dn_keep);

  // blocking conditions
  wire lv_d = voltage_pct < lv_level;
  wire oc_d = current_l1 > oc_level || current_l2 > oc_level ||
              current_l3 > oc_level;
  wire blocked = lv_d || oc_d || ext_block || !ctrl_q[avr_pkg::CTRL_EN];

  // region selection, instant first, then fast window, then slow window
  wire in_inst = up_d && instant != 16'h0000 &&
                 absdev > {1'b0, instant};
  wire in_w2 = (up_d || dn_d) && absdev > {1'b0, w2_band};
  wire inverse = ctrl_q[avr_pkg::CTRL_INV];
  always_comb
  begin
    if (blocked || !(up_d || dn_d))
    begin
      region_d = avr_pkg::REG_NONE;
    end
    else if (in_inst)
    begin
      region_d = avr_pkg::REG_INST;
    end
    else if (in_w2)
    begin
      region_d = avr_pkg::REG_W2;
    end
    else
    begin
      region_d = avr_pkg::REG_W1;
    end
  end

  // inverse mode integrates deviation in the second window only, so the wait there shrinks as deviation grows
  wire [31:0] step = (region_d == avr_pkg::REG_W2 && inverse) ? {15'h0, absdev} :
                     32'h0000_0001;
  wire [31:0] thr_inv = 32'({16'h0, t2_ticks} * 32'(avr_pkg::PCT_DIV));
  wire [31:0] thr = (region_d == avr_pkg::REG_W2) ?
                    (inverse ? thr_inv : {16'h0, t2_ticks}) :
                    {16'h0, t1_ticks};
  wire [31:0] acc_sum = acc_q + step;
  wire gap_ok = gap_q >= min_gap;
  wire tick = ce && sample_valid;
  wire fire_timed = (region_d == avr_pkg::REG_W1 || region_d == avr_pkg::REG_W2) &&
                    acc_d >= thr && gap_ok;
  wire fire_inst = region_d == avr_pkg::REG_INST && gap_ok;
  wire fire = tick && (fire_timed || fire_inst);
  wire fire_lower = fire && (region_d == avr_pkg::REG_INST || up_d);
  wire fire_raise = fire && !fire_lower && dn_d;

  always_comb
  begin
    if (region_d != region_q)
    begin
      acc_d = step;
    end
    else if (acc_sum < acc_q)
    begin
      acc_d = acc_q;
    end
    else
    begin
      acc_d = acc_sum;
    end
  end

  // position scaling, shared by both analogue sources
  wire [15:0] pos_raw = ctrl_q[avr_pkg::CTRL_SRC] ? pos_di_voltage : pos_resistance;
  wire [47:0] pos_prod = {32'h0, pos_raw} * {16'h0, gain_q};
  wire [7:0] pos_d = POS_BASE_ADD(pos_prod[avr_pkg::GAIN_SHIFT +: 8]);

  function automatic logic [7:0] POS_BASE_ADD(input logic [7:0] v);
    POS_BASE_ADD = v + avr_pkg::POS_BASE;
  endfunction

  wire [avr_pkg::EV_W-1:0] ev_set = {tick && oc_d && !oc_q, tick && lv_d && !lv_q,
                                     fire_lower, fire_raise};
  wire [avr_pkg::EV_W-1:0] status_d = (status_q & ~clr_bits) | ev_set;

  setting_bank u_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .we(bank_we),
    .waddr(awaddr_q[6:2]),
    .wdata(wdata_q[15:0]),
    .raddr(araddr_q[6:2]),
    .rdata_q(bank_rdata),
    .grp(ctrl_q[avr_pkg::CTRL_GRP]),
    .act_q(act)
  );

  // write channel: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= avr_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? avr_pkg::RESP_OKAY : avr_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel: two edges to let the bank register its word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_q <= avr_pkg::RD_IDLE;
      araddr_q <= '0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= avr_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      case (rd_q)
        avr_pkg::RD_IDLE:
        begin
          if (s_axi_arvalid)
          begin
            araddr_q <= s_axi_araddr;
            s_axi_arready <= 1'b0;
            rd_q <= avr_pkg::RD_FETCH;
          end
        end
        avr_pkg::RD_FETCH:
        begin
          rd_q <= avr_pkg::RD_LOAD;
        end
        avr_pkg::RD_LOAD:
        begin
          s_axi_rdata <= rd_word;
          s_axi_rresp <= rd_ok ? avr_pkg::RESP_OKAY : avr_pkg::RESP_SLVERR;
          s_axi_rvalid <= 1'b1;
          rd_q <= avr_pkg::RD_RESP;
        end
        avr_pkg::RD_RESP:
        begin
          if (s_axi_rready)
          begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
            rd_q <= avr_pkg::RD_IDLE;
          end
        end
        default:
        begin
          rd_q <= avr_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // software registers; a new event wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= avr_pkg::CTRL_RST;
      mask_q <= avr_pkg::MASK_RST;
      gain_q <= avr_pkg::GAIN_RST;
      status_q <= '0;
      irq_q <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_fire && wr_ctrl)
      begin
        ctrl_q <= wr_merge_ctrl[avr_pkg::CTRL_W-1:0];
      end
      if (wr_fire && wr_mask)
      begin
        mask_q <= wr_merge_mask[avr_pkg::EV_W-1:0];
      end
      if (wr_fire && wr_gain)
      begin
        gain_q <= wr_merge_gain;
      end
      status_q <= status_d;
      irq_q <= |(status_d & mask_q);
    end
  end

  // regulator state, advanced once per measurement tick
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
      lv_q <= 1'b0;
      oc_q <= 1'b0;
      ext_q <= 1'b0;
      region_q <= avr_pkg::REG_NONE;
      acc_q <= '0;
      gap_q <= '0;
      tap_position_q <= '0;
    end
    else if (tick)
    begin
      up_q <= up_d;
      dn_q <= dn_d;
      lv_q <= lv_d;
      oc_q <= oc_d;
      ext_q <= ext_block;
      region_q <= region_d;
      acc_q <= (fire || region_d == avr_pkg::REG_NONE) ? 32'h0 : acc_d;
      gap_q <= fire ? 16'h0001 : (gap_q == 16'hffff ? gap_q : gap_q + 16'h0001);
      tap_position_q <= pos_d;
    end
  end

  // commands last one clock, one direction only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      raise_cmd_q <= 1'b0;
      lower_cmd_q <= 1'b0;
    end
    else if (ce)
    begin
      raise_cmd_q <= fire_raise;
      lower_cmd_q <= fire_lower;
    end
  end

endmodule // tap_changer_voltage_regulator
`default_nettype wire

// >>> avr_pkg.sv
package avr_pkg;

  // register map, byte addresses on the register bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_POS_GAIN = 8'h10;
  localparam int BANK_SEL_BIT = 7;

  // control register fields
  localparam int CTRL_W = 4;
  localparam int CTRL_EN = 0;
  localparam int CTRL_SRC = 1;
  localparam int CTRL_GRP = 2;
  localparam int CTRL_INV = 3;
  localparam logic [3:0] CTRL_RST = 4'h8;

  // sticky event bits, shared by status and mask
  localparam int EV_W = 4;
  localparam int EV_RAISE = 0;
  localparam int EV_LOWER = 1;
  localparam int EV_LV = 2;
  localparam int EV_OC = 3;
  localparam logic [3:0] MASK_RST = 4'h0;

  // state register field positions
  localparam int ST_PICK_LSB = 0;
  localparam int ST_BLK_LSB = 4;
  localparam int ST_REG_LSB = 8;
  localparam int ST_POS_LSB = 16;

  // setting bank: two groups of sixteen 16-bit words
  localparam int PW = 16;
  localparam int NPAR = 16;
  localparam int NGRP = 2;
  localparam int BANK_AW = 5;
  localparam int P_TARGET = 0;
  localparam int P_W1_HI = 1;
  localparam int P_W1_LO = 2;
  localparam int P_W2 = 3;
  localparam int P_INSTANT = 4;
  localparam int P_LV_BLOCK = 5;
  localparam int P_T1 = 6;
  localparam int P_T2 = 7;
  localparam int P_MIN_GAP = 8;
  localparam int P_OC_LEVEL = 9;

  // arithmetic constants
  localparam int PCT_DIV = 100;
  localparam int HYST_PCT = 3;
  localparam logic [7:0] POS_BASE = 8'h01;
  localparam int GAIN_SHIFT = 16;
  localparam logic [31:0] GAIN_RST = 32'h0000_0000;
  localparam int TIME_BASE_MS = 5;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    RD_IDLE = 4'b0001,
    RD_FETCH = 4'b0010,
    RD_LOAD = 4'b0100,
    RD_RESP = 4'b1000
  } rd_state_t;

  typedef enum logic [3:0] {
    REG_NONE = 4'b0001,
    REG_W1 = 4'b0010,
    REG_W2 = 4'b0100,
    REG_INST = 4'b1000
  } region_t;

endpackage

// >>> setting_bank.sv
`timescale 1ns/1ps
`default_nettype none
module setting_bank (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [avr_pkg::BANK_AW-1:0] waddr,
  input wire logic [avr_pkg::PW-1:0] wdata,
  // readback port
  input wire logic [avr_pkg::BANK_AW-1:0] raddr,
  output logic [avr_pkg::PW-1:0] rdata_q,
  // active group, all words in parallel
  input wire logic grp,
  output logic [avr_pkg::NPAR*avr_pkg::PW-1:0] act_q
);

  logic [avr_pkg::PW-1:0] mem_q [avr_pkg::NGRP*avr_pkg::NPAR];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rdata_q <= '0;
    end
    else if (ce)
    begin
      rdata_q <= mem_q[raddr];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < avr_pkg::NGRP * avr_pkg::NPAR; gi++)
    begin : g_word
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          mem_q[gi] <= '0;
        end
        else if (ce && we && waddr == avr_pkg::BANK_AW'(gi))
        begin
          mem_q[gi] <= wdata;
        end
      end
    end
    // group switch reaches the regulator one edge later
    for (gi = 0; gi < avr_pkg::NPAR; gi++)
    begin : g_act
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          act_q[gi*avr_pkg::PW +: avr_pkg::PW] <= '0;
        end
        else if (ce)
        begin
          act_q[gi*avr_pkg::PW +: avr_pkg::PW] <= mem_q[{grp, (avr_pkg::BANK_AW - 1)'(gi)}];
        end
      end
    end
  endgenerate

endmodule // setting_bank
`default_nettype wire

// >>> avr_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module avr_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // regulator
  input wire logic sample_valid,
  input wire logic ext_block,
  input wire logic raise_cmd_q,
  input wire logic lower_cmd_q,
  input wire logic [7:0] tap_position_q
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire logic cmd = raise_cmd_q | lower_cmd_q;
  sequence rd_wait;
    !s_axi_rvalid ##1 !s_axi_rvalid ##1 s_axi_rvalid;
  endsequence
  AST_BOTH:
  assert property (!(raise_cmd_q && lower_cmd_q)) else $error("raise and lower together");
  AST_PULSE:
  assert property (cmd |=> !cmd) else $error("command wider than one cycle");
  AST_TICK:
  assert property ($rose(cmd) |-> $past(ce && sample_valid)) else $error("command off tick");
  AST_EXT:
  assert property (ce && sample_valid && ext_block |=> !cmd) else $error("command when blocked");
  AST_POS:
  assert property (!(ce && sample_valid) |=> $stable(tap_position_q))
    else $error("position moved off tick");
  AST_WRESP:
  assert property (ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("late write response");
  AST_BUSY:
  assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready during response");
  AST_RLAT:
  assert property (ce && s_axi_arvalid && s_axi_arready |=> rd_wait)
    else $error("read latency wrong");
  AST_RHOLD:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
endmodule // avr_asserts
bind tap_changer_voltage_regulator avr_asserts u_avr_asserts (.*);
`default_nettype wire

// >>> tap_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module tap_drive_model #(
  parameter int PERIOD = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // fault seen by the outside relay
  input wire logic fault_req,
  // toward the regulator
  output logic sample_valid,
  output logic ext_block
);
  // time base shortened from 5 ms so runs stay short
  logic [7:0] cnt_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 8'h00;
      sample_valid <= 1'b0;
      ext_block <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q == 8'(PERIOD - 1)) ? 8'h00 : cnt_q + 8'h01;
      sample_valid <= (cnt_q == 8'(PERIOD - 1));
      ext_block <= fault_req;
    end
  end
endmodule // tap_drive_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, fault_req = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rv;
  logic [15:0] voltage_pct = 16'h2710, current_l1 = 16'h0064, current_l2 = 16'h0000;
  logic [15:0] current_l3 = 16'h0000, pos_resistance = 16'h0000, pos_di_voltage = 16'h0000;
  logic sample_valid, ext_block, raise_cmd_q, lower_cmd_q, irq_q;
  logic [7:0] tap_position_q;
  int bad_count = 0, tests_run = 0, n_up = 0, n_dn = 0, cyc = 0;
  tap_changer_voltage_regulator u_tap_changer_voltage_regulator (.*);
  tap_drive_model #(.PERIOD(8)) u_tap_drive_model (.aclk(aclk), .aresetn(aresetn),
    .fault_req(fault_req), .sample_valid(sample_valid), .ext_block(ext_block));
  always #2.5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    if (raise_cmd_q === 1'b1) n_up++;
    if (lower_cmd_q === 1'b1) n_dn++;
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    @(posedge aclk);
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w)
    begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (w && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      aw = aw && s_axi_awready !== 1'b1;
      w = w && s_axi_wready !== 1'b1;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic par(input logic [31:0] g, input int i, input logic [15:0] v);
    wr(32'h80 + g * 32'h40 + 32'(i * 4), {16'h0000, v}, avr_pkg::RESP_OKAY);
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      while (sample_valid !== 1'b1) @(posedge aclk);
    end
    repeat (2) @(posedge aclk);
  endtask
  task automatic vt(input logic [15:0] v, input int n);
    voltage_pct <= v;
    tick(n);
  endtask
  task automatic calm;
    vt(16'h2710, 2);
    n_up = 0;
    n_dn = 0;
  endtask
  task automatic t_regs;
    logic [15:0] p [10] = '{16'h2710, 16'h0064, 16'h0064, 16'h012c, 16'h0320,
      16'h1388, 16'h0003, 16'h0004, 16'h0000, 16'h03e8};
    rd(32'(avr_pkg::OFS_CTRL));
    chk("ctrl reset", rv, 32'(avr_pkg::CTRL_RST));
    rd(32'(avr_pkg::OFS_MASK));
    chk("mask reset", rv, 32'(avr_pkg::MASK_RST));
    rd(32'h0000_0020);
    chk("unmapped resp", 32'(rr), 32'(avr_pkg::RESP_SLVERR));
    chk("unmapped data", rv, 32'h0);
    wr(32'h0000_0020, 32'h1, avr_pkg::RESP_SLVERR);
    for (int i = 0; i < 10; i++) par(32'h0, i, p[i]);
    rd(32'h0000_0080);
    chk("target readback", rv, 32'h2710);
    wr(32'(avr_pkg::OFS_CTRL), 32'h1, avr_pkg::RESP_OKAY);
    $display("regs done");
  endtask
  task automatic t_window;
    calm();
    vt(16'h27d8, 2);
    chk("early lower", n_dn, 0);
    vt(16'h27d8, 1);
    chk("lower after t1", n_dn, 1);
    vt(16'h2710, 1);
    vt(16'h27d8, 2);
    vt(16'h2710, 1);
    vt(16'h27d8, 2);
    chk("timer cleared", n_dn, 1);
    vt(16'h27d8, 1);
    chk("timer restarts", n_dn, 2);
    calm();
    vt(16'h2648, 3);
    chk("raise below", n_up, 1);
    chk("no lower below", n_dn, 0);
    $display("window done");
  endtask
  task automatic t_hyst;
    int rel;
    rel = 100 * (avr_pkg::PCT_DIV - avr_pkg::HYST_PCT) / avr_pkg::PCT_DIV;
    calm();
    vt(16'h27d8, 1);
    vt(16'(32'h2710 + rel + 1), 1);
    rd(32'(avr_pkg::OFS_STATE));
    chk("pickup held", 32'(rv[avr_pkg::ST_PICK_LSB]), 32'h1);
    vt(16'(32'h2710 + rel - 1), 1);
    rd(32'(avr_pkg::OFS_STATE));
    chk("pickup released", 32'(rv[avr_pkg::ST_PICK_LSB]), 32'h0);
    $display("hysteresis done");
  endtask
  task automatic t_second;
    par(32'h0, avr_pkg::P_T1, 16'h000a);
    wr(32'(avr_pkg::OFS_CTRL), 32'h9, avr_pkg::RESP_OKAY);
    calm();
    vt(16'h286e, 3);
    chk("inverse fast", n_dn, 1);
    calm();
    vt(16'h280a, 5);
    chk("first window inside", n_dn, 0);
    vt(16'h280a, 5);
    chk("first window fires", n_dn, 1);
    wr(32'(avr_pkg::OFS_CTRL), 32'h1, avr_pkg::RESP_OKAY);
    calm();
    vt(16'h286e, 3);
    chk("definite wait", n_dn, 0);
    vt(16'h286e, 2);
    chk("definite fire", n_dn, 1);
    par(32'h0, avr_pkg::P_T1, 16'h0003);
    par(32'h0, avr_pkg::P_MIN_GAP, 16'h0002);
    calm();
    vt(16'h2a94, 6);
    chk("instant burst", n_dn, 3);
    n_dn = 0;
    vt(16'h27d8, 2);
    chk("instant over", n_dn, 0);
    vt(16'h27d8, 1);
    chk("window resumes", n_dn, 1);
    par(32'h0, avr_pkg::P_MIN_GAP, 16'h0000);
    $display("second window done");
  endtask
  task automatic t_block;
    calm();
    vt(16'h0fa0, 5);
    chk("lv no raise", n_up, 0);
    rd(32'(avr_pkg::OFS_STATUS));
    chk("lv status", 32'(rv[avr_pkg::EV_LV]), 32'h1);
    wr(32'(avr_pkg::OFS_MASK), 32'h4, avr_pkg::RESP_OKAY);
    @(posedge aclk);
    chk("irq on", 32'(irq_q), 32'h1);
    calm();
    wr(32'(avr_pkg::OFS_STATUS), 32'h4, avr_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq cleared", 32'(irq_q), 32'h0);
    current_l1 <= 16'h07d0;
    vt(16'h25e4, 5);
    chk("oc no raise", n_up, 0);
    rd(32'(avr_pkg::OFS_STATUS));
    chk("oc status", 32'(rv[avr_pkg::EV_OC]), 32'h1);
    current_l1 <= 16'h0064;
    calm();
    fault_req <= 1'b1;
    vt(16'h25e4, 5);
    chk("ext no raise", n_up, 0);
    fault_req <= 1'b0;
    vt(16'h25e4, 4);
    chk("raise after ext", n_up, 1);
    $display("blocking done");
  endtask
  task automatic t_group;
    logic [15:0] p [10] = '{16'h283c, 16'h0064, 16'h0064, 16'h03e8, 16'h0000,
      16'h1388, 16'h0001, 16'h0004, 16'h0000, 16'h03e8};
    for (int i = 0; i < 10; i++) par(32'h1, i, p[i]);
    calm();
    voltage_pct <= 16'h283c;
    wr(32'(avr_pkg::OFS_CTRL), 32'h5, avr_pkg::RESP_OKAY);
    tick(3);
    chk("target shift", n_dn, 0);
    vt(16'h2710, 1);
    chk("group one timing", n_up, 1);
    wr(32'(avr_pkg::OFS_CTRL), 32'h1, avr_pkg::RESP_OKAY);
    vt(16'h2710, 2);
    chk("group zero back", n_up, 1);
    $display("group done");
  endtask
  task automatic t_pos;
    wr(32'(avr_pkg::OFS_POS_GAIN), 32'h0000_199a, avr_pkg::RESP_OKAY);
    pos_resistance <= 16'h00b4;
    tick(1);
    chk("pos resistance", 32'(tap_position_q), 32'h13);
    pos_di_voltage <= 16'h005a;
    wr(32'(avr_pkg::OFS_CTRL), 32'h3, avr_pkg::RESP_OKAY);
    tick(1);
    chk("pos di", 32'(tap_position_q), 32'ha);
    $display("position done");
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_window();
    t_hyst();
    t_second();
    t_block();
    t_group();
    t_pos();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
